// file: hw/cbc_pkg.sv
/*
  constants, encodings and timing counts for the conference bridge control logic.
  assumes a 200 mhz clock; keypad digits arrive already decoded as 4-bit codes.
*/
package cbc_pkg;
  localparam int CBC_CLK_HZ = 200_000_000;
  // keypad codes: 0-9 digits, 0xa star, 0xb pound / flat a
  localparam logic [3:0] CBC_KEY_STAR = 4'ha;
  localparam logic [3:0] CBC_KEY_POUND = 4'hb;
  // last digit of the dialed bridge number that still means primary
  localparam logic [3:0] CBC_PRIMARY_MIN = 4'h1;
  localparam logic [3:0] CBC_PRIMARY_MAX = 4'h5;
  // command codes as two bcd digits
  localparam logic [7:0] CBC_CMD_JOIN = 8'h00;
  localparam logic [7:0] CBC_CMD_PORT_MIN = 8'h01;
  localparam logic [7:0] CBC_CMD_PORT_MAX = 8'h57;
  localparam logic [7:0] CBC_CMD_TWO_WAY = 8'h70;
  localparam logic [7:0] CBC_CMD_BROADCAST = 8'h72;
  localparam logic [7:0] CBC_CMD_DROP_DIAL = 8'h73;
  localparam logic [7:0] CBC_CMD_DROP_QUIET = 8'h75;
  localparam logic [7:0] CBC_CMD_PAT_A = 8'h80;
  localparam logic [7:0] CBC_CMD_PAT_E = 8'h84;
  localparam logic [7:0] CBC_CMD_STOP = 8'h85;
  localparam logic [7:0] CBC_CMD_RELEASE = 8'h86;
  // no-answer timeout window in seconds
  localparam int CBC_TIMEOUT_MIN_S = 10;
  localparam int CBC_TIMEOUT_MAX_S = 100;
  localparam longint CBC_CYC_PER_S = CBC_CLK_HZ;
  // access burst and preemption tone lengths in milliseconds
  localparam int CBC_BURST_MS = 500;
  localparam int CBC_PREEMPT_MS = 200;
  localparam longint CBC_BURST_CYC = longint'(CBC_BURST_MS) * CBC_CLK_HZ / 1000;
  localparam longint CBC_PREEMPT_CYC = longint'(CBC_PREEMPT_MS) * CBC_CLK_HZ / 1000;

  typedef enum logic [2:0] {
    CBC_CONF = 3'b001,
    CBC_PRIVATE = 3'b010,
    CBC_ADLIB = 3'b100
  } cbc_mode_t;
endpackage

// file: hw/cbc_port_retry.sv
/*
  per-port automatic retry: alternates primary and secondary numbers
  on no-answer timeout and redials after a hang-up.
  assumes line status inputs are already synchronised to clk_i.
*/
`timescale 1ns/100ps
module cbc_port_retry
  import cbc_pkg::*;
#(
  parameter int CNT_W = 36
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic retry_en_i,
  input wire logic answered_i,
  input wire logic hangup_i,
  input wire logic drop_i,
  input wire logic [CNT_W-1:0] timeout_cyc_i,
  output logic dial_o,
  output logic use_secondary_o
);
  logic active_reg;
  logic [CNT_W-1:0] wait_reg;

  // one-cycle dial request; secondary flag selects which stored number
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_reg <= 1'b0;
      wait_reg <= '0;
      dial_o <= 1'b0;
      use_secondary_o <= 1'b0;
    end else begin
      dial_o <= 1'b0;
      if (drop_i) begin
        active_reg <= 1'b0;
      end else if (start_i) begin
        active_reg <= 1'b1;
        use_secondary_o <= 1'b0;
        wait_reg <= '0;
        dial_o <= 1'b1;
      end else if (active_reg && hangup_i) begin
        // answered may already read low on the hang-up cycle, so the pulse alone decides
        wait_reg <= '0;
        if (retry_en_i) begin
          dial_o <= 1'b1;
        end
      end else if (active_reg && answered_i) begin
        wait_reg <= '0;
      end else if (active_reg && retry_en_i) begin
        if (wait_reg >= timeout_cyc_i) begin
          wait_reg <= '0;
          use_secondary_o <= ~use_secondary_o;
          dial_o <= 1'b1;
        end else begin
          wait_reg <= wait_reg + 1'b1;
        end
      end
    end
  end

  retry_alternate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    dial_o && !$past(start_i) && !$past(answered_i) && !$past(hangup_i) |->
    use_secondary_o != $past(use_secondary_o))
    else $error("retry did not alternate numbers");
  retry_stop_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $past(!retry_en_i) && $past(!start_i) |-> !dial_o)
    else $error("dial while retry stopped");
endmodule

// file: hw/cbc_bridge_ctrl.sv
/*
  command interpreter of an automatic conference bridge: prefix role, two-digit
  commands, modes, auto-dialer control, tones and per-port retry.
  assumes a dtmf receiver delivering one key_valid_i pulse per key on clk_i, and
  line status per port synchronised on clk_i by the port interface.
*/
// Behaviour
// - no answer in timeout: dial secondary
// - keep alternating primary and secondary numbers
// - code 85 stops retry on all ports
// - hang-up redials unless stop or release code given
// - last digit 6-0: tandem, star prefix
// - last digit 1-5: primary, pound prefix
// - 72 broadcast, 70 two-way
// - port then 73 drops, dial tone
// - port then 75 drops, no tone
// - 86 releases dialers, 80-84 restart pattern
// - port number gives private talk, 00 rejoins
// - ad-lib after stop, 00 joins conference
// - access sends 700 hz burst
// - preemption plays short tone to originator
// - every command preceded by role prefix
// - codes 01-57 select conferee port
`timescale 1ns/100ps
module cbc_bridge_ctrl
  import cbc_pkg::*;
#(
  parameter int PORTS = 57,
  parameter longint TIMEOUT_CYC_MAX = longint'(CBC_TIMEOUT_MAX_S) * CBC_CYC_PER_S,
  parameter longint BURST_CYC = CBC_BURST_CYC,
  parameter longint PREEMPT_CYC = CBC_PREEMPT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic access_i,
  input wire logic [3:0] access_digit_i,
  input wire logic conf_end_i,
  input wire logic key_valid_i,
  input wire logic [3:0] key_i,
  input wire logic [6:0] timeout_s_i,
  input wire logic [PORTS-1:0] answered_i,
  input wire logic [PORTS-1:0] hangup_i,
  input wire logic [PORTS-1:0] preempt_i,
  output logic tandem_o,
  output cbc_pkg::cbc_mode_t mode_o,
  output logic broadcast_o,
  output logic [5:0] sel_port_o,
  output logic drop_o,
  output logic orig_dial_tone_o,
  output logic dialers_stopped_o,
  output logic dialers_released_o,
  output logic [2:0] pattern_o,
  output logic tone_700_o,
  output logic preempt_tone_o,
  output logic [PORTS-1:0] dial_o,
  output logic [PORTS-1:0] use_secondary_o
);
  localparam int CNT_W = 36;
  localparam int TONE_W = 32;

  // refused at elaboration: ports beyond the 01-57 codes, loads that overflow their
  // counters, and a burst shorter than its own check watches
  if (PORTS < 1 || PORTS > 57) begin : g_bad_ports
    $error("PORTS must be 1..57");
  end
  if (TIMEOUT_CYC_MAX < CBC_TIMEOUT_MAX_S || TIMEOUT_CYC_MAX >= (64'h1 << CNT_W)) begin : g_bad_to
    $error("timeout does not fit counter");
  end
  if (BURST_CYC < 8 || BURST_CYC >= (64'h1 << TONE_W)) begin : g_bad_burst
    $error("burst length out of range");
  end
  if (PREEMPT_CYC < 1 || PREEMPT_CYC >= (64'h1 << TONE_W)) begin : g_bad_preempt
    $error("preemption tone length out of range");
  end

  typedef enum logic [2:0] {
    CBC_IDLE = 3'b001,
    CBC_DIG1 = 3'b010,
    CBC_DIG2 = 3'b100
  } cbc_dec_t;

  cbc_dec_t dec_reg;
  logic [3:0] tens_reg;
  logic cmd_valid;
  logic [7:0] cmd;
  logic [7:0] port_bcd_reg;
  logic port_pend_reg;
  logic [TONE_W-1:0] burst_reg;
  logic [TONE_W-1:0] pre_reg;
  logic [PORTS-1:0] start_all;
  logic [CNT_W-1:0] timeout_cyc;
  logic prefix_ok;
  logic [6:0] t_clamped;

  // bcd port code to binary port index
  function automatic logic [5:0] bcd_bin(input logic [7:0] b);
    bcd_bin = 6'(b[7:4] * 4'd10 + b[3:0]);
  endfunction

  // access digit picks the role; the remaining digits imply tandem
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tandem_o <= 1'b0;
    end else if (access_i) begin
      tandem_o <= !(access_digit_i >= CBC_PRIMARY_MIN && access_digit_i <= CBC_PRIMARY_MAX);
    end
  end

  assign prefix_ok = tandem_o ? (key_i == CBC_KEY_STAR) : (key_i == CBC_KEY_POUND);

  // wrong prefix leaves the decoder idle so its digits fall away
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dec_reg <= CBC_IDLE;
      tens_reg <= 4'h0;
    end else if (key_valid_i) begin
      case (dec_reg)
        CBC_IDLE: if (prefix_ok) dec_reg <= CBC_DIG1;
        CBC_DIG1: begin
          tens_reg <= key_i;
          dec_reg <= (key_i <= 4'h9) ? CBC_DIG2 : CBC_IDLE;
        end
        CBC_DIG2: dec_reg <= CBC_IDLE;
        default: dec_reg <= CBC_IDLE;
      endcase
    end
  end

  assign cmd_valid = key_valid_i && dec_reg == CBC_DIG2 && key_i <= 4'h9;
  assign cmd = {tens_reg, key_i};

  // mode, drop and dialer control
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_o <= CBC_CONF;
      broadcast_o <= 1'b0;
      sel_port_o <= 6'h00;
      drop_o <= 1'b0;
      orig_dial_tone_o <= 1'b0;
      dialers_stopped_o <= 1'b0;
      dialers_released_o <= 1'b0;
      pattern_o <= 3'h0;
      port_bcd_reg <= 8'h00;
      port_pend_reg <= 1'b0;
      start_all <= '0;
    end else begin
      drop_o <= 1'b0;
      start_all <= '0;
      if (conf_end_i) begin
        mode_o <= CBC_CONF;
        broadcast_o <= 1'b0;
        dialers_stopped_o <= 1'b0;
        dialers_released_o <= 1'b0;
        orig_dial_tone_o <= 1'b0;
        port_pend_reg <= 1'b0;
      end else if (access_i) begin
        start_all <= '1;
      end else if (cmd_valid) begin
        port_pend_reg <= 1'b0;
        if (cmd >= CBC_CMD_PORT_MIN && cmd <= CBC_CMD_PORT_MAX) begin
          port_bcd_reg <= cmd;
          port_pend_reg <= 1'b1;
          sel_port_o <= bcd_bin(cmd);
          mode_o <= dialers_stopped_o ? CBC_ADLIB : CBC_PRIVATE;
        end else if (cmd == CBC_CMD_JOIN) begin
          mode_o <= CBC_CONF;
          orig_dial_tone_o <= 1'b0;
        end else if (cmd == CBC_CMD_BROADCAST) begin
          broadcast_o <= 1'b1;
        end else if (cmd == CBC_CMD_TWO_WAY) begin
          broadcast_o <= 1'b0;
        end else if ((cmd == CBC_CMD_DROP_DIAL || cmd == CBC_CMD_DROP_QUIET) && port_pend_reg) begin
          drop_o <= 1'b1;
          sel_port_o <= bcd_bin(port_bcd_reg);
          orig_dial_tone_o <= (cmd == CBC_CMD_DROP_DIAL);
        end else if (cmd == CBC_CMD_STOP) begin
          dialers_stopped_o <= 1'b1;
        end else if (cmd == CBC_CMD_RELEASE) begin
          dialers_released_o <= 1'b1;
        end else if (cmd >= CBC_CMD_PAT_A && cmd <= CBC_CMD_PAT_E && dialers_released_o) begin
          pattern_o <= 3'(cmd[3:0]);
          dialers_released_o <= 1'b0;
          dialers_stopped_o <= 1'b0;
          start_all <= '1;
        end
      end
    end
  end

  // the access burst and preemption tone are fixed-length pulses
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      burst_reg <= '0;
      pre_reg <= '0;
    end else begin
      if (access_i) burst_reg <= TONE_W'(BURST_CYC);
      else if (burst_reg != '0) burst_reg <= burst_reg - 1'b1;
      if (|preempt_i) pre_reg <= TONE_W'(PREEMPT_CYC);
      else if (pre_reg != '0) pre_reg <= pre_reg - 1'b1;
    end
  end

  assign tone_700_o = burst_reg != '0;
  assign preempt_tone_o = pre_reg != '0;

  // out-of-range settings are clamped into the documented window
  assign t_clamped = timeout_s_i < 7'(CBC_TIMEOUT_MIN_S) ? 7'(CBC_TIMEOUT_MIN_S) :
                     timeout_s_i > 7'(CBC_TIMEOUT_MAX_S) ? 7'(CBC_TIMEOUT_MAX_S) : timeout_s_i;
  assign timeout_cyc = CNT_W'(TIMEOUT_CYC_MAX / CBC_TIMEOUT_MAX_S) * CNT_W'(t_clamped);

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    cbc_port_retry #(.CNT_W(CNT_W)) u_retry (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .start_i(start_all[p]),
      .retry_en_i(!dialers_stopped_o && !dialers_released_o),
      .answered_i(answered_i[p]),
      .hangup_i(hangup_i[p]),
      .drop_i(drop_o && sel_port_o == 6'(p + 1)),
      .timeout_cyc_i(timeout_cyc),
      .dial_o(dial_o[p]),
      .use_secondary_o(use_secondary_o[p])
    );
  end

  role_select_a: assert property (@(posedge clk_i) disable iff (reset_i)
    access_i && access_digit_i == 4'h7 |=> tandem_o)
    else $error("digit 7 did not select tandem");
  role_primary_a: assert property (@(posedge clk_i) disable iff (reset_i)
    access_i && access_digit_i == 4'h3 |=> !tandem_o)
    else $error("digit 3 did not select primary");
  broadcast_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_valid && !conf_end_i && !access_i && cmd == CBC_CMD_BROADCAST |=> broadcast_o)
    else $error("broadcast not set");
  drop_tone_a: assert property (@(posedge clk_i) disable iff (reset_i)
    drop_o |-> $past(port_pend_reg) && (orig_dial_tone_o == ($past(cmd) == CBC_CMD_DROP_DIAL)))
    else $error("drop without port or wrong tone");
  stop_all_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_valid && !conf_end_i && !access_i && cmd == CBC_CMD_STOP |=> dialers_stopped_o)
    else $error("stop code ignored");
  burst_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
    access_i |=> tone_700_o [*8])
    else $error("access burst too short");
  preempt_tone_a: assert property (@(posedge clk_i) disable iff (reset_i)
    |preempt_i |=> preempt_tone_o)
    else $error("preemption tone missing");
  prefix_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    dec_reg == CBC_IDLE && key_valid_i && !prefix_ok |=> dec_reg == CBC_IDLE)
    else $error("wrong prefix accepted");
  port_select_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_valid && !conf_end_i && !access_i && cmd == 8'h12 |=> sel_port_o == 6'd12 && mode_o != CBC_CONF)
    else $error("port select failed");
endmodule

// file: sim/cbc_phone_model.sv
/*
  conferee telephones on the far side of the switched network.
  assumes dial_i pulses come from the bridge; the bench asks for hang-ups.
*/
`timescale 1ns/100ps
module cbc_phone_model #(
  parameter int PORTS = 4
) (
  input wire logic clk_i,
  input wire logic [PORTS-1:0] dial_i,
  input wire logic [PORTS-1:0] answer_en_i,
  input wire logic [PORTS-1:0] hang_req_i,
  output logic [PORTS-1:0] answered_o,
  output logic [PORTS-1:0] hangup_o
);
  // per-port ring count; a higher port answers later, so prompt and slow replies both occur
  int ring [PORTS];
  initial begin
    answered_o = '0;
    hangup_o = '0;
    for (int p = 0; p < PORTS; p++) ring[p] = 0;
  end
  always @(negedge clk_i) begin
    for (int p = 0; p < PORTS; p++) begin
      hangup_o[p] <= hang_req_i[p] && answered_o[p];
      if (dial_i[p]) begin
        answered_o[p] <= 1'b0;
        ring[p] <= answer_en_i[p] ? p + 3 : 0;
      end else if (ring[p] == 1) begin
        answered_o[p] <= 1'b1;
        ring[p] <= 0;
      end else if (ring[p] > 1) begin
        ring[p] <= ring[p] - 1;
      end
      // a hang-up is only a pulse while the line is answered
      if (hang_req_i[p] && answered_o[p]) begin
        answered_o[p] <= 1'b0;
      end
    end
  end
endmodule

// file: sim/conference_bridge_control_bench.sv
/*
  self-checking bench of the bridge control block with four ports.
  assumes the phone model on the port side; keys are driven at falling edges.
*/
`timescale 1ns/100ps
module conference_bridge_control_bench;
  import cbc_pkg::*;
  localparam int P = 4;
  logic clk_i = 1'b0, reset_i = 1'b1, access_i = 1'b0, conf_end_i = 1'b0, key_valid_i = 1'b0;
  logic [3:0] access_digit_i = 4'h3, key_i = 4'h0;
  logic [6:0] timeout_s_i = 7'h0a;
  logic [P-1:0] answered_i, hangup_i, dial_o, use_secondary_o;
  logic [P-1:0] preempt_i = '0, answer_en = 4'he, hang_req = '0;
  logic tandem_o, broadcast_o, drop_o, orig_dial_tone_o, dialers_stopped_o;
  logic dialers_released_o, tone_700_o, preempt_tone_o;
  cbc_mode_t mode_o;
  logic [5:0] sel_port_o;
  logic [2:0] pattern_o;
  int mismatches = 0, checks = 0, drops = 0, n;
  // code, output select, expected value
  logic [19:0] rows [22] = '{20'h72_0_01, 20'h70_0_00, 20'h86_2_01, 20'h80_1_00, 20'h86_2_01,
    20'h81_1_01, 20'h86_2_01, 20'h82_1_02, 20'h86_2_01, 20'h83_1_03, 20'h86_2_01, 20'h84_1_04,
    20'h85_3_01, 20'h01_4_01, 20'h00_7_01, 20'h02_4_02, 20'h73_5_01, 20'h00_5_00, 20'h04_4_04,
    20'h75_5_00, 20'h00_7_01, 20'h12_4_0c};

  // short timeout: 10 cycles per second of setting keeps retry runs brief
  cbc_bridge_ctrl #(.PORTS(P), .TIMEOUT_CYC_MAX(1000), .BURST_CYC(16), .PREEMPT_CYC(16)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .access_i(access_i), .access_digit_i(access_digit_i),
    .conf_end_i(conf_end_i), .key_valid_i(key_valid_i), .key_i(key_i),
    .timeout_s_i(timeout_s_i), .answered_i(answered_i), .hangup_i(hangup_i),
    .preempt_i(preempt_i), .tandem_o(tandem_o), .mode_o(mode_o), .broadcast_o(broadcast_o),
    .sel_port_o(sel_port_o), .drop_o(drop_o), .orig_dial_tone_o(orig_dial_tone_o),
    .dialers_stopped_o(dialers_stopped_o), .dialers_released_o(dialers_released_o),
    .pattern_o(pattern_o), .tone_700_o(tone_700_o), .preempt_tone_o(preempt_tone_o),
    .dial_o(dial_o), .use_secondary_o(use_secondary_o));
  cbc_phone_model #(.PORTS(P)) phones (.clk_i(clk_i), .dial_i(dial_o), .answer_en_i(answer_en),
    .hang_req_i(hang_req), .answered_o(answered_i), .hangup_o(hangup_i));

  always #2.5 clk_i = ~clk_i;
  always @(negedge clk_i) if (drop_o === 1'b1) drops++;

  function automatic logic [7:0] get(input logic [3:0] s);
    case (s)
      4'h0: get = {7'h0, broadcast_o};
      4'h1: get = {5'h0, pattern_o};
      4'h2: get = {7'h0, dialers_released_o};
      4'h3: get = {7'h0, dialers_stopped_o};
      4'h4: get = {2'h0, sel_port_o};
      4'h5: get = {7'h0, orig_dial_tone_o};
      default: get = {5'h0, mode_o};
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic key(input logic [3:0] k);
    @(negedge clk_i);
    key_valid_i = 1'b1;
    key_i = k;
    @(negedge clk_i);
    key_valid_i = 1'b0;
  endtask
  task automatic cmd(input logic [3:0] pfx, input logic [3:0] d1, input logic [3:0] d2);
    key(pfx);
    key(d1);
    key(d2);
    repeat (2) @(negedge clk_i);
  endtask
  task automatic do_access(input logic [3:0] d);
    @(negedge clk_i);
    access_i = 1'b1;
    access_digit_i = d;
    @(negedge clk_i);
    access_i = 1'b0;
  endtask
  // looks at the current cycle first, so a dial pulse launched by the last edge is not lost
  task automatic wait_dial(input int p, input int lim, output int cnt);
    cnt = 0;
    while (dial_o[p] !== 1'b1 && cnt < lim) begin
      @(negedge clk_i);
      cnt++;
    end
    @(negedge clk_i);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize;
  end

  initial begin
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    check(8'(mode_o), 8'(CBC_CONF));
    check({4'h0, dial_o}, 8'h00);
    $display("reset test done");
    do_access(4'h3);
    wait_dial(0, 4, n);
    check(8'(n < 4), 8'h1);
    check({7'h0, use_secondary_o[0]}, 8'h0);
    check({7'h0, tone_700_o}, 8'h1);
    wait_dial(0, 300, n);
    check(8'(n >= 99 && n <= 103), 8'h1);
    check({7'h0, use_secondary_o[0]}, 8'h1);
    check({7'h0, tone_700_o}, 8'h0);
    wait_dial(0, 300, n);
    check(8'(n >= 99 && n <= 103), 8'h1);
    check({7'h0, use_secondary_o[0]}, 8'h0);
    // the phone model samples on this same edge, so requests land after it
    hang_req[1] <= 1'b1;
    @(negedge clk_i);
    hang_req[1] <= 1'b0;
    wait_dial(1, 6, n);
    check(8'(n < 6), 8'h1);
    preempt_i[2] = 1'b1;
    @(negedge clk_i);
    preempt_i[2] = 1'b0;
    @(negedge clk_i);
    check({7'h0, preempt_tone_o}, 8'h1);
    repeat (20) @(negedge clk_i);
    check({7'h0, preempt_tone_o}, 8'h0);
    $display("retry and tone test done");
    for (int i = 0; i < 22; i++) begin
      cmd(CBC_KEY_POUND, rows[i][19:16], rows[i][15:12]);
      check(get(rows[i][11:8]), rows[i][7:0]);
    end
    check(8'(drops), 8'h2);
    $display("command table done");
    repeat (8) @(negedge clk_i);
    hang_req <= 4'he;
    @(negedge clk_i);
    hang_req <= '0;
    n = 0;
    repeat (250) begin
      @(negedge clk_i);
      if (dial_o !== '0) n++;
    end
    check(8'(n), 8'h0);
    cmd(CBC_KEY_STAR, 4'h7, 4'h2);
    check({7'h0, broadcast_o}, 8'h0);
    $display("stop and prefix test done");
    for (int d = 0; d < 10; d++) begin
      @(negedge clk_i);
      conf_end_i = 1'b1;
      @(negedge clk_i);
      conf_end_i = 1'b0;
      do_access(4'(d));
      @(negedge clk_i);
      check({7'h0, tandem_o}, 8'(d < 1 || d > 5));
    end
    cmd(CBC_KEY_POUND, 4'h7, 4'h2);
    check({7'h0, broadcast_o}, 8'h0);
    cmd(CBC_KEY_STAR, 4'h7, 4'h2);
    check({7'h0, broadcast_o}, 8'h1);
    $display("tandem test done");
    @(negedge clk_i);
    reset_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check({6'h0, tandem_o, broadcast_o}, 8'h00);
    check(8'(mode_o), 8'(CBC_CONF));
    reset_i = 1'b0;
    cmd(CBC_KEY_POUND, 4'h7, 4'h2);
    check({7'h0, broadcast_o}, 8'h1);
    $display("mid-run reset test done");
    summarize;
  end
endmodule
